// [rtl/npc_map.vh]
// constants for the next-protocol comparator stage: register indices, fields,
// reset values and header byte positions. definitions only.
`ifndef NPC_MAP_VH
`define NPC_MAP_VH

// register word indices on the plain register port
`define NPC_REG_CTRL      4'h0
`define NPC_REG_WIN1      4'h1
`define NPC_REG_POS       4'h2
`define NPC_REG_HDR       4'h3
`define NPC_REG_M2_LO     4'h4
`define NPC_REG_M2_HI     4'h5
`define NPC_REG_K2_LO     4'h6
`define NPC_REG_K2_HI     4'h7
`define NPC_REG_STATUS    4'h8
`define NPC_REG_FRAMES    4'h9
`define NPC_REG_HITS      4'ha

// control register fields
`define NPC_CTRL_MODE_LSB  0
`define NPC_CTRL_NXT_LSB   2
`define NPC_CTRL_CLR_BIT   5
`define NPC_CTRL_UPD_BIT   6
`define NPC_CTRL_CLEN_LSB  8
// window 1 register fields
`define NPC_WIN1_VAL_LSB   0
`define NPC_WIN1_MSK_LSB   8
`define NPC_WIN1_POS_LSB   16
// position register fields
`define NPC_POS_W2_LSB     0
`define NPC_POS_FLOW_LSB   8
// header register fields
`define NPC_HDR_LEN_LSB    0
`define NPC_HDR_CKS_LSB    8

// protocol select codes
`define NPC_MODE_IPV4      2'h0
`define NPC_MODE_IPV6      2'h1
`define NPC_MODE_GEN32     2'h2
`define NPC_MODE_GEN128    2'h3

// expected version nibbles
`define NPC_VER_IPV4       4'h4
`define NPC_VER_IPV6       4'h6

// next-stage codes that are not reserved
`define NPC_NXT_ETH2       3'h1
`define NPC_NXT_IP1        3'h2
`define NPC_NXT_IP2        3'h3
`define NPC_NXT_PTP        3'h5

// ipv4 header byte positions
`define NPC_POS_VERSION    8'h00
`define NPC_POS_FRAG_HI    8'h06
`define NPC_POS_FRAG_LO    8'h07
`define NPC_MF_BIT         5

// reset values and counter limit
`define NPC_RST_CKS_LEN    2'h2
`define NPC_CNT_MAX        8'hff

`endif

// [rtl/masked_match.v]
// masked compare of a captured field against a programmed value.
// assumes value, mask and field are stable while hit is sampled.
`timescale 1ns/100ps
module masked_match #(
  parameter W = 8
) (
  // programmed match set
  input  wire [W-1:0] value,
  input  wire [W-1:0] mask,
  // captured field
  input  wire [W-1:0] field,
  input  wire         got,
  // result
  output wire         enabled,
  output wire         hit
);
  assign enabled = |mask;
  // an all-zero mask imposes nothing; otherwise the field must be present
  assign hit = ~enabled | (got & (((field ^ value) & mask) == {W{1'b0}}));
endmodule // masked_match

// [rtl/window_gather.v]
// collects n consecutive header bytes starting at a programmed position.
// assumes pos_now is the header-relative index of the byte on data.
`timescale 1ns/100ps
module window_gather #(
  parameter N = 1
) (
  // clock and reset
  input  wire           mclk,
  input  wire           nrst,
  // byte stream
  input  wire           take,
  input  wire           first,
  input  wire [7:0]     pos_now,
  input  wire [7:0]     data,
  // window start
  input  wire [7:0]     start,
  // captured field, first byte in the top lane
  output reg  [8*N-1:0] field_q,
  output reg            got_q
);
  // span of the window beyond its first byte, cut to the index width
  localparam [31:0] SPAN = N - 1;
  wire [8:0] last = {1'b0, start} + SPAN[8:0];
  wire       in_w = ({1'b0, pos_now} >= {1'b0, start}) && ({1'b0, pos_now} <= last);
  wire [8*N-1:0] shifted;

  genvar g;
  generate
    for (g = 1; g < N; g = g + 1) begin : lane
      assign shifted[8*g+7:8*g] = field_q[8*g-1:8*g-8];
    end
  endgenerate
  assign shifted[7:0] = data;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      field_q <= {8*N{1'b0}};
      got_q   <= 1'b0;
    end else if (take) begin
      if (in_w)
        field_q <= shifted;
      if (first)
        got_q <= in_w && ({1'b0, pos_now} == last);
      else if (in_w && ({1'b0, pos_now} == last))
        got_q <= 1'b1;
    end
  end
endmodule // window_gather

// [rtl/next_protocol_comparator.v]
// next-protocol check stage of the ip/udp/ach comparator: registers, header
// byte tracking, version and fragment checks, two masked windows, verdict.
// assumes header bytes arrive at most one per clock from the preceding stage, with
// hdr_first on byte 0 of this header and hdr_last on its final byte.
//
// Overview of operation
// R01: two-bit select picks ipv4, ipv6, generic modes
// R02: version must be 4 or 6; generic unchecked
// R03: ipv4 needs fragment offset and mf zero
// R04: window one masks 8 bits against protocol byte
// R05: all-zero mask disables its window
// R06: window one starts at 5-bit position
// R07: window two masks a 64-bit field
// R08: window two starts at 7-bit position
// R09: next header start is programmed length
// R10: software keeps one header order and length
// R11: 3-bit selector names next comparator, some reserved
// R12: flow window starts at 5-bit offset
// R13: clear enable zeroes udp checksum, ipv4 only
// R14: update enable rewrites last two payload bytes
// R15: software never sets both checksum enables
// R16: ipv4 checksum position passed to rewriter
// R17: 2-bit checksum length passed to rewriter
// R18: match only if checks and windows agree
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "npc_map.vh"
module next_protocol_comparator (
  // clock and reset
  input  wire        mclk,
  input  wire        nrst,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_q,
  // header byte stream
  input  wire        hdr_valid,
  input  wire        hdr_first,
  input  wire        hdr_last,
  input  wire [7:0]  hdr_data,
  // position markers
  output reg         flow_start_q,
  output reg         next_start_q,
  // verdict
  output reg         result_valid_q,
  output reg         proto_match_q,
  output reg  [2:0]  next_stage_q,
  output reg         next_stage_ok_q,
  output reg  [7:0]  next_hdr_pos_q,
  // checksum hand-over to the rewriter
  output reg         cks_clear_q,
  output reg         cks_update_q,
  output reg         cks_pos_valid_q,
  output reg  [7:0]  cks_pos_q,
  output reg  [1:0]  cks_len_q
);

  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_BODY  = 3'b010;
  localparam [2:0] ST_JUDGE = 3'b100;

  // configuration registers
  reg  [1:0]  protocol_select_q;
  reg  [2:0]  next_stage_selector_q;
  reg         zero_en_q;
  reg         comp_en_q;
  reg  [1:0]  checksum_length_q;
  reg  [7:0]  first_value_q;
  reg  [7:0]  first_mask_q;
  reg  [4:0]  first_pos_q;
  reg  [6:0]  second_pos_q;
  reg  [4:0]  flow_pos_q;
  reg  [7:0]  header_length_q;
  reg  [7:0]  checksum_position_q;
  reg  [63:0] second_value_q;
  reg  [63:0] second_mask_q;

  // frame tracking
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [7:0]  cnt_q;
  reg  [3:0]  version_q;
  reg         frag_bad_q;
  reg         frag_seen_q;
  reg  [15:0] frames_q;
  reg  [15:0] hits_q;
  reg  [5:0]  last_status_q;

  wire [7:0]  pos_now;
  wire        take;
  wire [7:0]  w1_field;
  wire        w1_got;
  wire [63:0] w2_field;
  wire        w2_got;
  wire        w1_en;
  wire        w1_hit;
  wire        w2_en;
  wire        w2_hit;
  reg         ver_ok;
  reg         frag_ok;
  wire        verdict;
  wire        both_cks;

  // reserved selector codes give no onward stage
  function stage_ok;
    input [2:0] code;
    begin
      case (code)
        `NPC_NXT_ETH2, `NPC_NXT_IP1, `NPC_NXT_IP2, `NPC_NXT_PTP: stage_ok = 1'b1;
        default: stage_ok = 1'b0;
      endcase
    end
  endfunction

  // register writes
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      protocol_select_q     <= `NPC_MODE_IPV4;
      next_stage_selector_q <= 3'h0;
      zero_en_q             <= 1'b0;
      comp_en_q             <= 1'b0;
      checksum_length_q     <= `NPC_RST_CKS_LEN;
      first_value_q         <= 8'h00;
      first_mask_q          <= 8'h00;
      first_pos_q           <= 5'h00;
      second_pos_q          <= 7'h00;
      flow_pos_q            <= 5'h00;
      header_length_q       <= 8'h00;
      checksum_position_q   <= 8'h00;
      second_value_q        <= 64'h0;
      second_mask_q         <= 64'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `NPC_REG_CTRL: begin
          protocol_select_q     <= reg_wdata[`NPC_CTRL_MODE_LSB+1:`NPC_CTRL_MODE_LSB]; // R01
          next_stage_selector_q <= reg_wdata[`NPC_CTRL_NXT_LSB+2:`NPC_CTRL_NXT_LSB]; // R11
          zero_en_q             <= reg_wdata[`NPC_CTRL_CLR_BIT];
          comp_en_q             <= reg_wdata[`NPC_CTRL_UPD_BIT];
          checksum_length_q     <= reg_wdata[`NPC_CTRL_CLEN_LSB+1:`NPC_CTRL_CLEN_LSB]; // R17
        end
        `NPC_REG_WIN1: begin
          first_value_q <= reg_wdata[`NPC_WIN1_VAL_LSB+7:`NPC_WIN1_VAL_LSB];
          first_mask_q  <= reg_wdata[`NPC_WIN1_MSK_LSB+7:`NPC_WIN1_MSK_LSB];
          first_pos_q   <= reg_wdata[`NPC_WIN1_POS_LSB+4:`NPC_WIN1_POS_LSB]; // R06
        end
        `NPC_REG_POS: begin
          second_pos_q <= reg_wdata[`NPC_POS_W2_LSB+6:`NPC_POS_W2_LSB]; // R08
          flow_pos_q   <= reg_wdata[`NPC_POS_FLOW_LSB+4:`NPC_POS_FLOW_LSB]; // R12
        end
        `NPC_REG_HDR: begin
          header_length_q     <= reg_wdata[`NPC_HDR_LEN_LSB+7:`NPC_HDR_LEN_LSB]; // R09
          checksum_position_q <= reg_wdata[`NPC_HDR_CKS_LSB+7:`NPC_HDR_CKS_LSB]; // R16
        end
        `NPC_REG_M2_LO: second_value_q[31:0]  <= reg_wdata;
        `NPC_REG_M2_HI: second_value_q[63:32] <= reg_wdata;
        `NPC_REG_K2_LO: second_mask_q[31:0]   <= reg_wdata;
        `NPC_REG_K2_HI: second_mask_q[63:32]  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // register reads, data one cycle after the strobe
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `NPC_REG_CTRL:   reg_rdata_q <= {22'h0, checksum_length_q, 1'b0, comp_en_q,
                                         zero_en_q, next_stage_selector_q,
                                         protocol_select_q};
        `NPC_REG_WIN1:   reg_rdata_q <= {11'h0, first_pos_q, first_mask_q, first_value_q};
        `NPC_REG_POS:    reg_rdata_q <= {19'h0, flow_pos_q, 1'b0, second_pos_q};
        `NPC_REG_HDR:    reg_rdata_q <= {16'h0, checksum_position_q, header_length_q};
        `NPC_REG_M2_LO:  reg_rdata_q <= second_value_q[31:0];
        `NPC_REG_M2_HI:  reg_rdata_q <= second_value_q[63:32];
        `NPC_REG_K2_LO:  reg_rdata_q <= second_mask_q[31:0];
        `NPC_REG_K2_HI:  reg_rdata_q <= second_mask_q[63:32];
        `NPC_REG_STATUS: reg_rdata_q <= {24'h0, both_cks, state_q[0], last_status_q};
        `NPC_REG_FRAMES: reg_rdata_q <= {16'h0, frames_q};
        `NPC_REG_HITS:   reg_rdata_q <= {16'h0, hits_q};
        default:         reg_rdata_q <= 32'h0;
      endcase
    end else begin
      reg_rdata_q <= 32'h0;
    end
  end

  // header byte index: byte 0 is the one flagged first
  assign take    = hdr_valid && (hdr_first || state_q == ST_BODY);
  assign pos_now = hdr_first ? 8'h00 : cnt_q;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (hdr_valid && hdr_first) state_d = hdr_last ? ST_JUDGE : ST_BODY;
      ST_BODY:  if (hdr_valid && hdr_last) state_d = ST_JUDGE;
      ST_JUDGE: state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q     <= ST_IDLE;
      cnt_q       <= 8'h00;
      version_q   <= 4'h0;
      frag_bad_q  <= 1'b0;
      frag_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take) begin
        if (pos_now != `NPC_CNT_MAX)
          cnt_q <= pos_now + 8'h01;
        if (hdr_first) begin
          version_q   <= hdr_data[7:4];
          frag_bad_q  <= 1'b0;
          frag_seen_q <= 1'b0;
        end
        // mf flag and the 13-bit fragment offset must all be zero
        if (pos_now == `NPC_POS_FRAG_HI && (hdr_data[`NPC_MF_BIT:0] != 6'h00)) // R03
          frag_bad_q <= 1'b1;
        if (pos_now == `NPC_POS_FRAG_LO) begin
          frag_seen_q <= 1'b1;
          if (hdr_data != 8'h00)
            frag_bad_q <= 1'b1; // R03
        end
      end
    end
  end

  // position markers for the flow stage and the following header
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flow_start_q <= 1'b0;
      next_start_q <= 1'b0;
    end else begin
      flow_start_q <= take && (pos_now == {3'h0, flow_pos_q}); // R12
      next_start_q <= take && (pos_now == header_length_q); // R09
    end
  end

  // window captures
  window_gather #(.N(1)) u_win1 (
    .mclk    (mclk),
    .nrst    (nrst),
    .take    (take),
    .first   (hdr_first),
    .pos_now (pos_now),
    .data    (hdr_data),
    .start   ({3'h0, first_pos_q}), // R06
    .field_q (w1_field),
    .got_q   (w1_got)
  );

  window_gather #(.N(8)) u_win2 (
    .mclk    (mclk),
    .nrst    (nrst),
    .take    (take),
    .first   (hdr_first),
    .pos_now (pos_now),
    .data    (hdr_data),
    .start   ({1'b0, second_pos_q}), // R08
    .field_q (w2_field),
    .got_q   (w2_got)
  );

  masked_match #(.W(8)) u_cmp1 (
    .value   (first_value_q),
    .mask    (first_mask_q),
    .field   (w1_field), // R04
    .got     (w1_got),
    .enabled (w1_en), // R05
    .hit     (w1_hit)
  );

  masked_match #(.W(64)) u_cmp2 (
    .value   (second_value_q),
    .mask    (second_mask_q),
    .field   (w2_field), // R07
    .got     (w2_got),
    .enabled (w2_en), // R05
    .hit     (w2_hit)
  );

  // mode checks
  always @* begin
    ver_ok  = 1'b1;
    frag_ok = 1'b1;
    case (protocol_select_q)
      `NPC_MODE_IPV4: begin
        ver_ok  = (version_q == `NPC_VER_IPV4); // R02
        frag_ok = frag_seen_q && !frag_bad_q; // R03
      end
      `NPC_MODE_IPV6: ver_ok = (version_q == `NPC_VER_IPV6); // R02
      default: ver_ok = 1'b1; // R01
    endcase
  end

  assign verdict  = ver_ok && frag_ok && w1_hit && w2_hit; // R18
  assign both_cks = zero_en_q && comp_en_q;

  // verdict and hand-over, one cycle after the judging cycle
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      result_valid_q  <= 1'b0;
      proto_match_q   <= 1'b0;
      next_stage_q    <= 3'h0;
      next_stage_ok_q <= 1'b0;
      next_hdr_pos_q  <= 8'h00;
      cks_clear_q     <= 1'b0;
      cks_update_q    <= 1'b0;
      cks_pos_valid_q <= 1'b0;
      cks_pos_q       <= 8'h00;
      cks_len_q       <= `NPC_RST_CKS_LEN;
      last_status_q   <= 6'h00;
      frames_q        <= 16'h0;
      hits_q          <= 16'h0;
    end else if (state_q == ST_JUDGE) begin
      result_valid_q  <= 1'b1;
      proto_match_q   <= verdict; // R18
      next_stage_q    <= next_stage_selector_q; // R11
      next_stage_ok_q <= verdict && stage_ok(next_stage_selector_q); // R11
      next_hdr_pos_q  <= header_length_q; // R09
      // clearing applies to udp over ipv4 only; it wins a misconfigured pair
      cks_clear_q     <= verdict && zero_en_q
                         && (protocol_select_q == `NPC_MODE_IPV4); // R13
      cks_update_q    <= verdict && comp_en_q && !zero_en_q; // R14
      cks_pos_valid_q <= verdict && (protocol_select_q == `NPC_MODE_IPV4); // R16
      cks_pos_q       <= checksum_position_q; // R16
      cks_len_q       <= checksum_length_q; // R17
      last_status_q   <= {stage_ok(next_stage_selector_q), w2_hit && w2_en,
                          w1_hit && w1_en, frag_ok, ver_ok, verdict};
      frames_q        <= frames_q + 16'h1;
      if (verdict)
        hits_q <= hits_q + 16'h1;
    end else begin
      result_valid_q  <= 1'b0;
      cks_len_q       <= checksum_length_q; // R17
    end
  end

endmodule // next_protocol_comparator

// [sim/npc_src.sv]
// preceding pipeline stage model: sends one header byte per cycle, with an idle cycle before each odd-numbered byte when slow is set.
// assumes the bench fills fr and calls send at a rising edge.
`timescale 1ns/100ps
module npc_src (
  // clock and pacing
  input  wire        mclk,
  input  wire        slow,
  // header byte stream
  output logic       valid,
  output logic       first,
  output logic       last,
  output logic [7:0] data
);
  logic [7:0] fr [0:63];
  initial begin
    valid = 0;
    first = 0;
    last  = 0;
    data  = 8'h00;
  end
  // idle cycles carry a toggling byte so stale data never looks valid
  task send(input int n);
    for (int i = 0; i < n; i++) begin
      if (slow && i[0]) begin
        valid <= 1'b0;
        data  <= ~data;
        @(posedge mclk);
      end
      valid <= 1'b1;
      first <= (i == 0);
      last  <= (i == n - 1);
      data  <= fr[i];
      @(posedge mclk);
    end
    valid <= 1'b0;
    first <= 1'b0;
    last  <= 1'b0;
    repeat (3) begin
      data <= ~data;
      @(posedge mclk);
    end
  endtask
endmodule // npc_src

// [sim/npc_asserts.sv]
// port assertions for the next-protocol comparator.
// assumes it is bound to next_protocol_comparator.
`timescale 1ns/100ps
module npc_asserts (
  // clock and reset
  input logic        mclk,
  input logic        nrst,
  // register port and stream
  input logic        reg_rd,
  input logic [31:0] reg_rdata_q,
  input logic        hdr_valid,
  input logic        hdr_last,
  // outputs
  input logic        flow_start_q,
  input logic        next_start_q,
  input logic        result_valid_q,
  input logic        proto_match_q,
  input logic [2:0]  next_stage_q,
  input logic        next_stage_ok_q,
  input logic [7:0]  next_hdr_pos_q,
  input logic        cks_clear_q,
  input logic        cks_update_q,
  input logic        cks_pos_valid_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata_q == 32'h0)
    else $error("read data not zero outside read slot");
  AST_VERDICT_LAT: assert property (
    hdr_valid && hdr_last |=> !result_valid_q ##1 result_valid_q)
    else $error("verdict not two cycles after last byte");
  AST_VERDICT_CAUSE: assert property (
    result_valid_q |-> $past(hdr_valid, 2) && $past(hdr_last, 2))
    else $error("verdict without last byte");
  AST_HOLD: assert property (!result_valid_q |-> $stable(proto_match_q) &&
    $stable(next_stage_q) && $stable(next_hdr_pos_q))
    else $error("verdict changed between verdicts");
  AST_STAGE_OK: assert property (result_valid_q |-> next_stage_ok_q ==
    (proto_match_q && next_stage_q inside {3'h1, 3'h2, 3'h3, 3'h5}))
    else $error("next stage ok wrong");
  AST_CLR: assert property (cks_clear_q |-> proto_match_q && cks_pos_valid_q)
    else $error("checksum clear without match");
  AST_UPD: assert property (cks_update_q |-> proto_match_q && !cks_clear_q)
    else $error("checksum update wrong");
  AST_FLOW: assert property (flow_start_q |-> $past(hdr_valid) ##1 !flow_start_q)
    else $error("flow marker wrong");
  AST_NEXT: assert property (next_start_q |-> $past(hdr_valid) ##1 !next_start_q)
    else $error("next header marker wrong");
endmodule // npc_asserts
bind next_protocol_comparator npc_asserts chk (.mclk, .nrst, .reg_rd, .reg_rdata_q,
  .hdr_valid, .hdr_last, .flow_start_q, .next_start_q, .result_valid_q, .proto_match_q,
  .next_stage_q, .next_stage_ok_q, .next_hdr_pos_q, .cks_clear_q, .cks_update_q,
  .cks_pos_valid_q);

// [sim/ip_ach_next_protocol_comparator_bench.sv]
// random frames and settings against a reference verdict.
// assumes npc_src and the bound checker are compiled before it.
`timescale 1ns/100ps
module ip_ach_next_protocol_comparator_bench;
  logic        mclk, nrst, reg_wr, reg_rd, slow, rd_d;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q;
  wire         hdr_valid, hdr_first, hdr_last;
  wire  [7:0]  hdr_data;
  logic        flow_start_q, next_start_q, result_valid_q, proto_match_q;
  logic        next_stage_ok_q, cks_clear_q, cks_update_q, cks_pos_valid_q;
  logic [2:0]  next_stage_q;
  logic [7:0]  next_hdr_pos_q, cks_pos_q;
  logic [1:0]  cks_len_q;
  logic [15:0] seed;
  logic [31:0] rq [$];
  logic [29:0] vq [$];
  logic [29:0] vout;
  int          failures, total_checks, cyc, fcnt, ncnt, frames, hits;

  next_protocol_comparator dut (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .hdr_valid, .hdr_first, .hdr_last, .hdr_data, .flow_start_q,
    .next_start_q, .result_valid_q, .proto_match_q, .next_stage_q, .next_stage_ok_q,
    .next_hdr_pos_q, .cks_clear_q, .cks_update_q, .cks_pos_valid_q, .cks_pos_q, .cks_len_q);
  npc_src src (.mclk, .slow, .valid(hdr_valid), .first(hdr_first), .last(hdr_last),
    .data(hdr_data));

  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end

  function logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  task tally_and_finish;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task cmp_rd(input logic [31:0] got);
    logic [31:0] e;
    e = rq.pop_front();
    total_checks++;
    if (got !== e) begin
      failures++;
      $display("Error %0t read got %h exp %h", $time, got, e);
    end
  endtask

  task cmp_vd(input logic [29:0] got);
    logic [29:0] e;
    e = vq.pop_front();
    total_checks++;
    if (got !== e) begin
      failures++;
      $display("Error %0t verdict got %h exp %h", $time, got, e);
    end
  endtask

  // one register access per cycle; a read pushes d as the expected data
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    if (!w) rq.push_back(d);
    @(posedge mclk);
  endtask

  task idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask

  task trial;
    logic [15:0] a, b, c, x;
    logic [1:0]  md;
    logic [2:0]  sel;
    logic        cl, up, ok, vo, fo, h1, h2;
    logic [7:0]  v1, m1, hl, cp;
    logic [4:0]  p1, fp;
    logic [6:0]  p2;
    logic [31:0] w;
    logic [63:0] v2, m2, w2;
    a = rnd();
    b = rnd();
    c = rnd();
    md = a[1:0];
    sel = a[4:2];
    cl = a[5];
    up = a[6] & !a[5];
    v1 = a[15:8];
    m1 = (b[1:0] == 0) ? 8'h00 : b[15:8];
    p1 = b[6:2];
    p2 = {1'b0, c[5:0]};
    hl = c[15:8];
    x = rnd();
    fp = x[4:0];
    cp = x[15:8];
    v2 = {rnd(), rnd(), rnd(), rnd()};
    m2 = (c[7:6] == 0) ? 64'h0 : {rnd(), rnd(), rnd(), rnd()};
    w = {22'h0, b[8:7], 1'b0, up, cl, sel, md};
    acc(1, 4'h0, w);
    acc(1, 4'h1, {11'h0, p1, m1, v1});
    acc(1, 4'h2, {19'h0, fp, 1'b0, p2});
    acc(1, 4'h3, {16'h0, cp, hl});
    acc(1, 4'h4, v2[31:0]);
    acc(1, 4'h5, v2[63:32]);
    acc(1, 4'h6, m2[31:0]);
    acc(1, 4'h7, m2[63:32]);
    acc(0, 4'h0, w);
    idle();
    for (int i = 0; i < 64; i++) begin
      x = rnd();
      src.fr[i] = x[7:0];
    end
    src.fr[0] = {(md == 2'h1) ? 4'h6 : 4'h4, 4'h5};
    src.fr[6] = 8'h00;
    src.fr[7] = 8'h00;
    src.fr[p1] = v1;
    for (int k = 0; k < 8; k++)
      src.fr[(p2 + k) % 64] = v2[63-8*k -: 8];
    x = rnd();
    if (x[15]) src.fr[x[7:0] % 40] ^= 8'h01 << x[10:8];
    slow = x[14];
    vo = 1'b1;
    if (md == 2'h0) vo = src.fr[0][7:4] == 4'h4;
    if (md == 2'h1) vo = src.fr[0][7:4] == 4'h6;
    fo = md != 2'h0 || (src.fr[6][5:0] == 0 && src.fr[7] == 0);
    h1 = m1 != 0 && ((src.fr[p1] ^ v1) & m1) == 0;
    for (int k = 0; k < 8; k++)
      w2[63-8*k -: 8] = src.fr[(p2 + k) % 64];
    h2 = m2 != 0 && p2 + 7 < 40 && ((w2 ^ v2) & m2) == 0;
    ok = vo && fo && (h1 || m1 == 0) && (h2 || m2 == 0);
    vq.push_back({ok, ok && (sel inside {3'h1, 3'h2, 3'h3, 3'h5}), ok & cl & (md == 2'h0),
      ok & up, ok & (md == 2'h0), sel, hl, cp, b[8:7], 2'd1, (hl < 40) ? 2'd1 : 2'd0});
    frames++;
    hits += ok;
    src.send(40);
    acc(0, 4'h8, {24'h0, 2'b01, (sel inside {3'h1, 3'h2, 3'h3, 3'h5}), h2, h1, fo, vo, ok});
  endtask

  always @(posedge mclk) begin
    rd_d <= reg_rd;
    cyc <= cyc + 1;
    if (cyc > 40000) begin
      failures++;
      tally_and_finish();
    end
  end

  always @(negedge mclk) begin
    if (rd_d === 1'b1) cmp_rd(reg_rdata_q);
    fcnt += (flow_start_q === 1'b1);
    ncnt += (next_start_q === 1'b1);
    if (result_valid_q === 1'b1) begin
      vout = {proto_match_q, next_stage_ok_q, cks_clear_q, cks_update_q, cks_pos_valid_q,
        next_stage_q, next_hdr_pos_q, cks_pos_q, cks_len_q, fcnt[1:0], ncnt[1:0]};
      cmp_vd(vout);
      fcnt = 0;
      ncnt = 0;
    end
  end

  initial begin
    nrst = 0;
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 0;
    reg_wdata = 0;
    slow = 0;
    seed = 16'hc5d1;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    acc(0, 4'h0, 32'h200);
    repeat (150) trial();
    acc(0, 4'h9, frames);
    acc(0, 4'ha, hits);
    acc(1, 4'h9, 32'h0);
    acc(0, 4'h9, frames);
    acc(0, 4'hb, 32'h0);
    idle();
    repeat (4) @(posedge mclk);
    if (rq.size() + vq.size() != 0) failures++;
    tally_and_finish();
  end
endmodule // ip_ach_next_protocol_comparator_bench
